// ==== rtl/cdp_pkg.sv ====
/*
  Shared constants and carriers of the correction descriptor parser:
  descriptor tags, flag byte layout, register offsets and views, states.
  Assumes one 50 MHz clock and APB register access with 32-bit data.
*/

package cdp_pkg;

  // ==========================================================
  // descriptor coding
  localparam logic [7:0] TAG_NET_INFO   = 8'hA0;
  localparam logic [7:0] TAG_CORRECTION = 8'hA1;
  localparam int         FLAG_TIME_BIT  = 7;
  localparam int         FLAG_POWER_BIT = 6;
  localparam int         FLAG_FREQ_BIT  = 5;
  localparam int         BURST_MSB      = 4;
  localparam int         BURST_LSB      = 3;
  localparam int         SCALE_MSB      = 2;
  localparam int         SCALE_LSB      = 0;
  localparam int         PMODE_BIT      = 7;
  // timing correction unit, counts of the reference clock
  localparam int         TIME_REF_MHZ   = 27;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_TIME     = 8'h08;
  localparam logic [7:0] OFF_POWER    = 8'h0C;
  localparam logic [7:0] OFF_FREQ     = 8'h10;
  localparam logic [7:0] OFF_CNT_OK   = 8'h14;
  localparam logic [7:0] OFF_CNT_SKIP = 8'h18;
  localparam logic [7:0] OFF_CNT_ERR  = 8'h1C;
  localparam int         CTRL_EN_BIT  = 0;
  localparam int         CTRL_FWD_BIT = 1;
  localparam int         CTRL_CLR_BIT = 2;
  localparam int         STAT_ERR_BIT = 0;
  localparam int         STAT_NEW_BIT = 1;
  localparam logic       CTRL_EN_RST  = 1'b1;
  localparam logic       CTRL_FWD_RST = 1'b1;

  typedef enum logic [1:0] {
    cdp_traffic_burst,
    cdp_common_signalling_burst,
    cdp_acquisition_burst,
    cdp_sync_burst
  } cdp_burst_e;

  // nine states need four bits
  typedef enum logic [3:0] {
    cdp_s_tag, cdp_s_len, cdp_s_body, cdp_s_skip,
    cdp_s_flags, cdp_s_time, cdp_s_power, cdp_s_fhi, cdp_s_flo
  } cdp_state_e;

  // decoded correction set
  typedef struct packed {
    logic        time_ok;
    logic        power_ok;
    logic        freq_ok;
    cdp_burst_e  burst;
    logic [15:0] time_scaled;
    logic        power_mode;
    logic [6:0]  power_value;
    logic [15:0] freq;
  } cdp_corr_s;

  // management byte stream
  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic [7:0] data;
  } cdp_mgmt_s;

  // register read views
  typedef struct packed {
    logic [12:0] zero;
    logic        ok;
    cdp_burst_e  burst;
    logic [15:0] scaled;
  } cdp_time_reg_s;

  typedef struct packed {
    logic [22:0] zero;
    logic        ok;
    logic        mode;
    logic [6:0]  value;
  } cdp_power_reg_s;

  typedef struct packed {
    logic [14:0] zero;
    logic        ok;
    logic [15:0] value;
  } cdp_freq_reg_s;

endpackage : cdp_pkg

// ==== rtl/cdp_time_scale.sv ====
/*
  Scales a signed timing correction by a power of two, filling the
  vacated low bits with a mid-range one-then-zeros pattern.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ns

module cdp_time_scale #(
  parameter int CORR_W  = 8,
  parameter int SCALE_W = 3,
  parameter int OUT_W   = 16
) (
  // correction in
  input  wire logic [CORR_W-1:0]  corr,
  input  wire logic [SCALE_W-1:0] shift,
  // scaled count out
  output logic      [OUT_W-1:0]   scaled
);

  initial
  begin
    if (OUT_W < CORR_W + (1 << SCALE_W) - 1)
      $error("cdp_time_scale: OUT_W too narrow for the shift range");
  end

  logic [OUT_W-1:0] ext;
  logic [OUT_W-1:0] fill;

  always_comb
  begin
    ext  = {{(OUT_W-CORR_W){corr[CORR_W-1]}}, corr};
    // halves the truncation error of the coarse step
    fill = (shift == '0) ? '0 : (OUT_W'(1) << (shift - SCALE_W'(1)));
    scaled = (ext << shift) | fill;
  end

endmodule : cdp_time_scale

// ==== rtl/cdp_event_counter.sv ====
/*
  Saturating event counter with synchronous clear.
  Assumes hit and clear come from logic on the same clock.
*/
`timescale 1ns/1ns

module cdp_event_counter #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // control
  input  wire logic         clear,
  input  wire logic         hit,
  // count
  output logic      [W-1:0] count
);

  initial
  begin
    if (W < 1 || W > 32)
      $error("cdp_event_counter: W must be 1 to 32");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
  } cdp_cnt_st_s;

  cdp_cnt_st_s q;
  cdp_cnt_st_s d;

  always_comb
  begin
    d = q;
    if (clear)
      d.cnt = '0;
    else if (hit && q.cnt != '1)
      d.cnt = q.cnt + W'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign count = q.cnt;

endmodule : cdp_event_counter

// ==== rtl/cdp_parser.sv ====
/*
  Correction descriptor parser: walks a byte stream of descriptors,
  passes network-layer info bodies to the management port, decodes
  correction message descriptors and keeps results in APB registers.
  Assumes the byte source shares pclk and holds a byte while in_ready
  is low; APB master follows the usual setup and access phases.
*/
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns

module cdp_parser #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // descriptor byte stream
  input  wire logic                in_valid,
  input  wire logic [7:0]          in_data,
  output logic                     in_ready,
  // management plane bytes
  output cdp_pkg::cdp_mgmt_s       mgmt,
  // decoded corrections
  output logic                     corr_valid,
  output cdp_pkg::cdp_corr_s       corr,
  output logic                     format_error
);

  initial
  begin
    if (CNT_W < 1 || CNT_W > 32)
      $error("cdp_parser: CNT_W must be 1 to 32");
  end

  // ==========================================================
  // state
  typedef struct packed {
    cdp_pkg::cdp_state_e state;
    logic [7:0]          tag;
    logic [7:0]          rem;
    logic                nli_first;
    logic                ft;
    logic                fp;
    logic                ff;
    logic [1:0]          burst;
    logic [2:0]          scale;
    logic [7:0]          tcorr;
    logic                pmode;
    logic [6:0]          pval;
    logic [7:0]          fhi;
    cdp_pkg::cdp_corr_s  corr;
    logic                corr_valid;
    logic                fmt_err;
    cdp_pkg::cdp_mgmt_s  mgmt;
    logic                ctrl_en;
    logic                ctrl_fwd;
    logic                err_sticky;
    logic                new_sticky;
    logic [31:0]         prdata;
    logic                slverr;
  } cdp_parser_st_s;

  cdp_parser_st_s q;
  cdp_parser_st_s d;

  // ==========================================================
  // combinational helpers
  logic               take;
  logic               commit;
  logic               skip_ev;
  logic               apb_setup;
  logic               apb_wr;
  logic [2:0]         need;
  logic [7:0]         scl_in;
  logic [15:0]        scaled;
  logic               cur_ft;
  logic               cur_fp;
  logic               cur_ff;
  logic               cur_pmode;
  logic [6:0]         cur_pval;
  logic [1:0]         cur_burst;
  cdp_pkg::cdp_corr_s result;
  logic [2:0]         ev;
  logic               cnt_clr;
  logic [CNT_W-1:0]   cnt [3];
  cdp_pkg::cdp_time_reg_s  time_view;
  cdp_pkg::cdp_power_reg_s pow_view;
  cdp_pkg::cdp_freq_reg_s  freq_view;

  assign take      = in_valid & q.ctrl_en;
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite & ~q.slverr;

  // flags, power and timing may arrive in the committing byte itself
  always_comb
  begin
    cur_ft    = q.ft;
    cur_fp    = q.fp;
    cur_ff    = q.ff;
    cur_pmode = q.pmode;
    cur_pval  = q.pval;
    scl_in    = q.tcorr;
    cur_burst = q.burst;
    if (q.state == cdp_pkg::cdp_s_flags)
    begin
      cur_ft = in_data[cdp_pkg::FLAG_TIME_BIT];
      cur_fp = in_data[cdp_pkg::FLAG_POWER_BIT];
      cur_ff = in_data[cdp_pkg::FLAG_FREQ_BIT];
      // a flags-only descriptor commits before burst is registered
      cur_burst = in_data[cdp_pkg::BURST_MSB:cdp_pkg::BURST_LSB];
    end
    if (q.state == cdp_pkg::cdp_s_power)
    begin
      cur_pmode = in_data[cdp_pkg::PMODE_BIT];
      cur_pval  = in_data[6:0];
    end
    if (q.state == cdp_pkg::cdp_s_time)
      scl_in = in_data;
  end

  cdp_time_scale #(
    .CORR_W  (8),
    .SCALE_W (3),
    .OUT_W   (16)
  ) u_scale (
    .corr   (scl_in),
    .shift  (q.scale),
    .scaled (scaled)
  );

  always_comb
  begin
    result             = '0;
    result.time_ok     = cur_ft;
    result.power_ok    = cur_fp;
    result.freq_ok     = cur_ff;
    result.burst       = cdp_pkg::cdp_burst_e'(cur_burst);
    result.time_scaled = cur_ft ? scaled : 16'h0000;
    result.power_mode  = cur_fp & cur_pmode;
    // signed half-dB step or quality figure, same format both ways
    result.power_value = cur_fp ? cur_pval : 7'h00;
    result.freq        = cur_ff ? {q.fhi, in_data} : 16'h0000;
  end

  // ==========================================================
  // parser and register file
  always_comb
  begin
    d              = q;
    d.corr_valid   = 1'b0;
    d.fmt_err      = 1'b0;
    d.mgmt.valid   = 1'b0;
    d.mgmt.first   = 1'b0;
    d.mgmt.last    = 1'b0;
    commit         = 1'b0;
    skip_ev        = 1'b0;
    cnt_clr        = 1'b0;
    need           = 3'h1 + {2'h0, in_data[cdp_pkg::FLAG_TIME_BIT]}
                   + {2'h0, in_data[cdp_pkg::FLAG_POWER_BIT]}
                   + {1'h0, in_data[cdp_pkg::FLAG_FREQ_BIT], 1'h0};

    if (take)
    begin
      case (q.state)
        cdp_pkg::cdp_s_tag:
        begin
          d.tag   = in_data;
          d.state = cdp_pkg::cdp_s_len;
        end
        cdp_pkg::cdp_s_len:
        begin
          d.rem = in_data;
          if (q.tag == cdp_pkg::TAG_NET_INFO)
          begin
            d.nli_first = 1'b1;
            d.state = (in_data == 8'h00) ? cdp_pkg::cdp_s_tag
                                         : cdp_pkg::cdp_s_body;
          end
          else if (q.tag == cdp_pkg::TAG_CORRECTION)
          begin
            if (in_data == 8'h00)
            begin
              d.fmt_err = 1'b1;
              d.state   = cdp_pkg::cdp_s_tag;
            end
            else
              d.state = cdp_pkg::cdp_s_flags;
          end
          else
          begin
            skip_ev = 1'b1;
            d.state = (in_data == 8'h00) ? cdp_pkg::cdp_s_tag
                                         : cdp_pkg::cdp_s_skip;
          end
        end
        cdp_pkg::cdp_s_body:
        begin
          // body is opaque; dropped when forwarding is off
          d.mgmt.valid = q.ctrl_fwd;
          d.mgmt.first = q.ctrl_fwd & q.nli_first;
          d.mgmt.last  = q.ctrl_fwd & (q.rem == 8'h01);
          d.mgmt.data  = in_data;
          d.nli_first  = 1'b0;
          d.rem        = q.rem - 8'h01;
          if (q.rem == 8'h01)
            d.state = cdp_pkg::cdp_s_tag;
        end
        cdp_pkg::cdp_s_skip:
        begin
          d.rem = q.rem - 8'h01;
          if (q.rem == 8'h01)
            d.state = cdp_pkg::cdp_s_tag;
        end
        cdp_pkg::cdp_s_flags:
        begin
          d.ft    = in_data[cdp_pkg::FLAG_TIME_BIT];
          d.fp    = in_data[cdp_pkg::FLAG_POWER_BIT];
          d.ff    = in_data[cdp_pkg::FLAG_FREQ_BIT];
          d.burst = in_data[cdp_pkg::BURST_MSB:cdp_pkg::BURST_LSB];
          d.scale = in_data[cdp_pkg::SCALE_MSB:cdp_pkg::SCALE_LSB];
          d.rem   = q.rem - 8'h01;
          if ({5'h00, need} != q.rem)
          begin
            // drop the rest so the next tag still lines up
            d.fmt_err = 1'b1;
            d.state   = (q.rem == 8'h01) ? cdp_pkg::cdp_s_tag
                                         : cdp_pkg::cdp_s_skip;
          end
          else if (in_data[cdp_pkg::FLAG_TIME_BIT])
            d.state = cdp_pkg::cdp_s_time;
          else if (in_data[cdp_pkg::FLAG_POWER_BIT])
            d.state = cdp_pkg::cdp_s_power;
          else if (in_data[cdp_pkg::FLAG_FREQ_BIT])
            d.state = cdp_pkg::cdp_s_fhi;
          else
            commit = 1'b1;
        end
        cdp_pkg::cdp_s_time:
        begin
          d.tcorr = in_data;
          d.rem   = q.rem - 8'h01;
          if (q.fp)
            d.state = cdp_pkg::cdp_s_power;
          else if (q.ff)
            d.state = cdp_pkg::cdp_s_fhi;
          else
            commit = 1'b1;
        end
        cdp_pkg::cdp_s_power:
        begin
          d.pmode = in_data[cdp_pkg::PMODE_BIT];
          d.pval  = in_data[6:0];
          d.rem   = q.rem - 8'h01;
          if (q.ff)
            d.state = cdp_pkg::cdp_s_fhi;
          else
            commit = 1'b1;
        end
        cdp_pkg::cdp_s_fhi:
        begin
          d.fhi   = in_data;
          d.rem   = q.rem - 8'h01;
          d.state = cdp_pkg::cdp_s_flo;
        end
        cdp_pkg::cdp_s_flo:
        begin
          d.rem  = q.rem - 8'h01;
          commit = 1'b1;
        end
        default:
          d.state = cdp_pkg::cdp_s_tag;
      endcase
    end

    if (commit)
    begin
      d.corr       = result;
      d.corr_valid = 1'b1;
      d.state      = cdp_pkg::cdp_s_tag;
    end

    // apb setup phase samples read data and decode error
    if (apb_setup)
    begin
      d.prdata = 32'h0000_0000;
      d.slverr = 1'b0;
      case (paddr)
        cdp_pkg::OFF_CTRL:
        begin
          d.prdata[cdp_pkg::CTRL_EN_BIT]  = q.ctrl_en;
          d.prdata[cdp_pkg::CTRL_FWD_BIT] = q.ctrl_fwd;
        end
        cdp_pkg::OFF_STATUS:
        begin
          d.prdata[cdp_pkg::STAT_ERR_BIT] = q.err_sticky;
          d.prdata[cdp_pkg::STAT_NEW_BIT] = q.new_sticky;
        end
        cdp_pkg::OFF_TIME:     d.prdata = time_view;
        cdp_pkg::OFF_POWER:    d.prdata = pow_view;
        cdp_pkg::OFF_FREQ:     d.prdata = freq_view;
        cdp_pkg::OFF_CNT_OK:   d.prdata = 32'(cnt[0]);
        cdp_pkg::OFF_CNT_SKIP: d.prdata = 32'(cnt[1]);
        cdp_pkg::OFF_CNT_ERR:  d.prdata = 32'(cnt[2]);
        default:               d.slverr = 1'b1;
      endcase
    end

    if (apb_wr && paddr == cdp_pkg::OFF_CTRL)
    begin
      d.ctrl_en  = pwdata[cdp_pkg::CTRL_EN_BIT];
      d.ctrl_fwd = pwdata[cdp_pkg::CTRL_FWD_BIT];
      cnt_clr    = pwdata[cdp_pkg::CTRL_CLR_BIT];
      // disabling abandons any descriptor in flight
      if (!pwdata[cdp_pkg::CTRL_EN_BIT])
        d.state = cdp_pkg::cdp_s_tag;
    end

    // write one to clear; a new event in the same cycle wins
    if (apb_wr && paddr == cdp_pkg::OFF_STATUS)
    begin
      if (pwdata[cdp_pkg::STAT_ERR_BIT])
        d.err_sticky = 1'b0;
      if (pwdata[cdp_pkg::STAT_NEW_BIT])
        d.new_sticky = 1'b0;
    end
    if (d.fmt_err)
      d.err_sticky = 1'b1;
    if (d.corr_valid)
      d.new_sticky = 1'b1;
  end

  always_comb
  begin
    time_view        = '0;
    time_view.ok     = q.corr.time_ok;
    time_view.burst  = q.corr.burst;
    time_view.scaled = q.corr.time_scaled;
    pow_view         = '0;
    pow_view.ok      = q.corr.power_ok;
    pow_view.mode    = q.corr.power_mode;
    pow_view.value   = q.corr.power_value;
    freq_view        = '0;
    freq_view.ok     = q.corr.freq_ok;
    freq_view.value  = q.corr.freq;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q          <= '0;
      q.ctrl_en  <= cdp_pkg::CTRL_EN_RST;
      q.ctrl_fwd <= cdp_pkg::CTRL_FWD_RST;
    end
    else
      q <= d;
  end

  // ==========================================================
  // event counters: committed, skipped, format errors
  assign ev = {d.fmt_err, skip_ev & take, d.corr_valid};

  for (genvar i = 0; i < 3; i++)
  begin : g_cnt
    cdp_event_counter #(
      .W (CNT_W)
    ) u_cnt (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (cnt_clr),
      .hit     (ev[i]),
      .count   (cnt[i])
    );
  end

  // ==========================================================
  // outputs
  assign in_ready     = q.ctrl_en;
  assign prdata       = q.prdata;
  assign pready       = 1'b1;
  assign pslverr      = q.slverr & psel & penable;
  assign mgmt         = q.mgmt;
  assign corr_valid   = q.corr_valid;
  assign corr         = q.corr;
  assign format_error = q.fmt_err;

endmodule : cdp_parser

// ==== testbench/cdp_monitor.sv ====
/*
  Concurrent checks on the parser's stream and result ports.
  Assumes binding to cdp_parser; one clock, async active-low reset.
*/
`timescale 1ns/1ns

module cdp_monitor (
  // clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // byte stream
  input wire logic               in_valid,
  input wire logic [7:0]         in_data,
  input wire logic               in_ready,
  // results
  input wire cdp_pkg::cdp_mgmt_s mgmt,
  input wire logic               corr_valid,
  input wire cdp_pkg::cdp_corr_s corr,
  input wire logic               format_error
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // =====
  // sequences
  sequence byte_taken;
    $past(in_valid && in_ready);
  endsequence
  sequence quiet_two;
    !corr_valid [*2];
  endsequence

  // =====
  // checks
  mgmt_copy_a: assert property (
    mgmt.valid |-> byte_taken ##0 mgmt.data == $past(in_data))
    else $error("mgmt byte not a copy of a taken byte");
  mgmt_mark_a: assert property (
    (mgmt.first || mgmt.last) |-> mgmt.valid && !corr_valid)
    else $error("mgmt marker without byte");
  stall_quiet_a: assert property (
    !(in_valid && in_ready) |=> !mgmt.valid && !corr_valid && !format_error)
    else $error("output without a taken byte");
  corr_cause_a: assert property (
    corr_valid |-> byte_taken)
    else $error("result not on a taken byte");
  corr_hold_a: assert property (
    !corr_valid |-> $stable(corr))
    else $error("result changed without commit");
  absent_zero_a: assert property (
    corr_valid |-> (corr.time_ok || corr.time_scaled == 16'h0000)
      && (corr.power_ok || {corr.power_mode, corr.power_value} == 8'h00)
      && (corr.freq_ok || corr.freq == 16'h0000))
    else $error("absent field not zero");
  corr_pulse_a: assert property (
    corr_valid |=> quiet_two)
    else $error("commits closer than three bytes");
  err_excl_a: assert property (
    format_error |-> !corr_valid ##1 !format_error)
    else $error("format error with result or held");
endmodule : cdp_monitor

bind cdp_parser cdp_monitor mon (.pclk, .presetn, .in_valid, .in_data,
  .in_ready, .mgmt, .corr_valid, .corr, .format_error);

// ==== testbench/cdp_byte_source.sv ====
/*
  Section demultiplexer model: hands descriptor bytes to the parser.
  Assumes the parser takes a byte on an edge with in_valid and in_ready.
*/
`timescale 1ns/1ns

module cdp_byte_source (
  // clock and reset
  input wire logic  pclk,
  input wire logic  presetn,
  // byte stream
  output logic       in_valid,
  output logic [7:0] in_data,
  input wire logic  in_ready
);
  // idle cycles after each byte, to stall the parser
  int gap = 0;

  initial
  begin
    in_valid = 1'b0;
    in_data  = 8'h00;
  end

  task automatic send(input logic [7:0] b[$]);
    while (presetn !== 1'b1)
      @(posedge pclk);
    foreach (b[i])
    begin
      in_valid <= 1'b1;
      in_data  <= b[i];
      @(posedge pclk);
      while (in_ready !== 1'b1)
        @(posedge pclk);
      // released line shows no stale byte
      if (gap > 0 || i == b.size() - 1)
      begin
        in_valid <= 1'b0;
        in_data  <= ~b[i];
        repeat (gap) @(posedge pclk);
      end
    end
  endtask : send
endmodule : cdp_byte_source

// ==== testbench/testbench.sv ====
/*
  Self-checking bench of the correction descriptor parser.
  Assumes the byte source model and the bound monitor are compiled.
*/
`timescale 1ns/1ns

module testbench;
  logic               pclk, presetn, psel, penable, pwrite;
  logic [7:0]         paddr, tc;
  logic [31:0]        pwdata, prdata, rd;
  logic               pready, pslverr, er;
  logic               in_valid, in_ready, corr_valid, format_error;
  logic [7:0]         in_data, pw;
  logic [15:0]        fr;
  cdp_pkg::cdp_mgmt_s mgmt;
  cdp_pkg::cdp_corr_s corr, got, e;
  int                 fail_count, comparisons, n_err, n_corr, exp_ok;
  logic [7:0]         mq[$];
  logic [1:0]         fq[$];

  cdp_parser dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_data, .in_ready,
    .mgmt, .corr_valid, .corr, .format_error);
  cdp_byte_source src (.pclk, .presetn, .in_valid, .in_data, .in_ready);

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    if (mgmt.valid === 1'b1)
    begin
      mq.push_back(mgmt.data);
      fq.push_back({mgmt.first, mgmt.last});
    end
    if (corr_valid === 1'b1)
    begin
      got = corr;
      n_corr++;
    end
    if (format_error === 1'b1)
      n_err++;
  end

  // =====
  // helpers
  task check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task rchk(input logic [7:0] a, input logic [31:0] x);
    xfer(a, 1'b0, 32'h0);
    check(rd, x);
  endtask : rchk

  task desc(input logic [7:0] b[$]);
    src.send(b);
    repeat (2) @(posedge pclk);
  endtask : desc

  function automatic logic [15:0] scaled(input logic [7:0] t, input int n);
    logic [15:0] v;
    v = {{8{t[7]}}, t} << n;
    if (n > 0)
      v[n-1] = 1'b1;
    return v;
  endfunction : scaled

  task print_verdict;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // =====
  // watchdog, far beyond the few hundred cycles needed
  initial
  begin
    #400000;
    fail_count++;
    print_verdict();
  end

  // =====
  // tests
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(cdp_pkg::OFF_CTRL, 32'h3);
    rchk(cdp_pkg::OFF_STATUS, 32'h0);
    xfer(8'h40, 1'b0, 32'h0);
    check({er, rd}, {1'b1, 32'h0});
    desc('{8'hA0, 8'h03, 8'h11, 8'h22, 8'h33});
    check({mq[0], mq[1], mq[2]}, 24'h112233);
    check({fq[0], fq[1], fq[2], 8'(mq.size())}, 14'h2103);
    for (int n = 0; n < 8; n++)
    begin
      src.gap = n % 2;
      tc = 8'h81 + 8'(n * 35);
      pw = {n[0], 7'(n * 13) - 7'd20};
      fr = 16'hF000 + 16'(n * 257);
      desc('{8'hA1, 8'h05, {3'b111, 2'(n), 3'(n)}, tc, pw, fr[15:8],
        fr[7:0]});
      e = '0;
      {e.time_ok, e.power_ok, e.freq_ok} = 3'b111;
      e.burst = cdp_pkg::cdp_burst_e'(2'(n));
      e.time_scaled = scaled(tc, n);
      {e.power_mode, e.power_value, e.freq} = {pw, fr};
      check(got, e);
      exp_ok++;
    end
    rchk(cdp_pkg::OFF_TIME, {13'h0, 3'b111, scaled(tc, 7)});
    rchk(cdp_pkg::OFF_POWER, {23'h0, 1'b1, pw});
    rchk(cdp_pkg::OFF_FREQ, {15'h0, 1'b1, fr});
    desc('{8'hA1, 8'h03, 8'h28, 8'hFF, 8'hFE});
    e = '0;
    e.freq_ok = 1'b1;
    e.burst   = cdp_pkg::cdp_common_signalling_burst;
    e.freq    = 16'hFFFE;
    check(got, e);
    desc('{8'hA1, 8'h02, 8'h58, 8'h7F});
    e = '0;
    e.power_ok    = 1'b1;
    e.burst       = cdp_pkg::cdp_sync_burst;
    e.power_value = 7'h7F;
    check(got, e);
    desc('{8'hA1, 8'h01, 8'h10});
    e = '0;
    e.burst = cdp_pkg::cdp_acquisition_burst;
    check(got, e);
    exp_ok += 3;
    desc('{8'hA1, 8'h04, 8'h80, 8'h01, 8'h02, 8'h03});
    check({n_err, n_corr}, {32'd1, exp_ok});
    rchk(cdp_pkg::OFF_STATUS, 32'h3);
    xfer(cdp_pkg::OFF_STATUS, 1'b1, 32'h3);
    rchk(cdp_pkg::OFF_STATUS, 32'h0);
    rchk(cdp_pkg::OFF_CNT_ERR, 32'h1);
    mq.delete();
    desc('{8'hA5, 8'h02, 8'hA1, 8'h01, 8'hA0, 8'h01, 8'h5A});
    check({8'(mq.size()), mq[0], n_corr}, {8'd1, 8'h5A, exp_ok});
    rchk(cdp_pkg::OFF_CNT_SKIP, 32'h1);
    rchk(cdp_pkg::OFF_CNT_OK, exp_ok);
    xfer(cdp_pkg::OFF_CTRL, 1'b1, 32'h1);
    desc('{8'hA0, 8'h01, 8'h77});
    check(mq.size(), 1);
    xfer(cdp_pkg::OFF_CTRL, 1'b1, 32'h0);
    check(in_ready, 1'b0);
    xfer(cdp_pkg::OFF_CTRL, 1'b1, 32'h7);
    rchk(cdp_pkg::OFF_CNT_OK, 32'h0);
    rchk(cdp_pkg::OFF_CTRL, 32'h3);
    print_verdict();
  end
endmodule : testbench
